// ### upc_map.vh
// Overview of operation
// (R1) With iso_sof_hold set, an armed IN packet waits for a start-of-frame token; with it clear, it goes on the next IN token.
// (R2) With iso_sof_hold set, an IN token that comes before the next start-of-frame token gets a zero-length packet.
// (R3) core_inhibit reads 1 after power-on reset and after a controller reset, and while it is 1 the controller is disabled.
// (R4) Software writes of 1 to core_inhibit are ignored, so only a reset can set it again.
// (R5) Software should clear core_inhibit only after the controller and transceiver are fully initialised.
// (R6) Writing 1 to the reset bit resets the whole controller and returns its registers to their defaults.
// (R7) Bus reset signalling sets the reset bit, so a read of it reports bus-reset status.
// (R8) A bus reset clears the function address and index, flushes the FIFOs, zeroes endpoint status, and enables all interrupts but suspend.
// (R9) suspend_state is set on entering suspend and cleared when software ends remote wakeup or reads the common interrupt flags after resume.
// (R10) Writing 1 to the resume bit forces remote wakeup, and writing 0 ends resume signalling.
// (R11) Bits 6 and 5 of power_control read 0 and ignore writes.
`ifndef UPC_MAP_VH
`define UPC_MAP_VH
`define UPC_OFF_POWER      8'h01
`define UPC_ADDR_POWER     12'h004
`define UPC_ADDR_IRQ_STAT  12'h010
`define UPC_ADDR_IRQ_EN    12'h014
`define UPC_ADDR_IRQ_CLR   12'h018
`define UPC_ADDR_STATUS    12'h01C
`define UPC_POWER_RESET    8'h10
`define UPC_BIT_ISO        7
`define UPC_BIT_INH        4
`define UPC_BIT_RST        3
`define UPC_BIT_RESUME     2
`define UPC_BIT_SUSMODE    1
`define UPC_BIT_SUSPEND_DETECT_ENABLE      0
`define UPC_IRQ_BUSRST     0
`define UPC_IRQ_SUSPEND    1
`define UPC_IRQ_RESUME     2
`define UPC_IRQ_SOF        3
`define UPC_IRQ_W          4
`define UPC_IRQ_EN_RESET   4'h0
`define UPC_IRQ_EN_BUSRST  4'hD
`define UPC_RESP_OKAY      2'b00
`define UPC_RESP_SLVERR    2'b10
`define UPC_ZERO8          8'h00
`define UPC_ZERO32         32'h0000_0000
`endif

// ### upc_sync.v
`timescale 1ns/100ps
module upc_sync #(
	parameter W = 1
) (
	input  wire         aclk,
	input  wire         aresetn,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] s1_reg;
	reg [W-1:0] s2_reg;
	always @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg <= {W{1'b0}};
			s2_reg <= {W{1'b0}};
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
		end
	end
	assign q = s2_reg;
endmodule

// ### upc_power_ctrl.v
`timescale 1ns/100ps
`include "upc_map.vh"
module upc_power_ctrl (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        bus_reset_det,
	input  wire        bus_suspend_det,
	input  wire        bus_resume_det,
	input  wire        sof_token,
	input  wire        in_token,
	input  wire        in_packet_armed,
	input  wire        common_irq_read,
	output reg         send_armed,
	output reg         send_zero_len,
	output reg         core_enable,
	output reg         resume_drive,
	output reg         bus_reset_clear,
	output reg  [6:0]  function_address_reg,
	output reg         irq
);
	// The reset, suspend, resume and start-of-frame events come from the link logic's domain, so they are synchronised here; in_token is not.
	wire [3:0] ev_sync;
	upc_sync #(.W(4)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({sof_token, bus_resume_det, bus_suspend_det, bus_reset_det}),
		.q       (ev_sync)
	);
	reg  [3:0] ev_prev_reg;
	wire [3:0] ev_rise = ev_sync & ~ev_prev_reg;
	wire       rst_ev  = ev_rise[`UPC_IRQ_BUSRST];
	wire       sus_ev  = ev_rise[`UPC_IRQ_SUSPEND];
	wire       res_ev  = ev_rise[`UPC_IRQ_RESUME];
	wire       sof_ev  = ev_rise[`UPC_IRQ_SOF];

	reg        iso_sof_hold_reg;
	reg        core_inhibit_reg;
	reg        bus_reset_flag_reg;
	reg        resume_reg;
	reg        suspend_state_reg;
	reg        suspend_detect_enable_reg;
	reg        resume_seen_reg;
	reg        sof_seen_reg;
	reg [`UPC_IRQ_W-1:0] irq_stat_reg;
	reg [`UPC_IRQ_W-1:0] irq_en_reg;
	reg        soft_rst_reg;

	// AXI write: address and data are latched independently, then answered together.
	reg        aw_hold_reg;
	reg        w_hold_reg;
	reg [11:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0]  w_strb_reg;
	assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
	wire [11:0] wa = aw_hold_reg ? aw_addr_reg : s_axi_awaddr;
	wire [31:0] wd = w_hold_reg ? w_data_reg : s_axi_wdata;
	wire [3:0]  ws = w_hold_reg ? w_strb_reg : s_axi_wstrb;
	wire aw_ok = aw_hold_reg || (s_axi_awvalid && s_axi_awready);
	wire w_ok  = w_hold_reg || (s_axi_wvalid && s_axi_wready);
	wire wr_go = aw_ok && w_ok;
	wire wr_lane0 = wr_go && ws[0];

	function known_addr;
		input [11:0] a;
		begin
			if (a == `UPC_ADDR_POWER) known_addr = 1'b1;
			else if (a == `UPC_ADDR_IRQ_STAT) known_addr = 1'b1;
			else if (a == `UPC_ADDR_IRQ_EN) known_addr = 1'b1;
			else if (a == `UPC_ADDR_IRQ_CLR) known_addr = 1'b1;
			else if (a == `UPC_ADDR_STATUS) known_addr = 1'b1;
			else known_addr = 1'b0;
		end
	endfunction

	wire pw_wr  = wr_lane0 && (wa == `UPC_ADDR_POWER);
	wire en_wr  = wr_lane0 && (wa == `UPC_ADDR_IRQ_EN);
	wire clr_wr = wr_lane0 && (wa == `UPC_ADDR_IRQ_CLR);
	wire fa_wr  = wr_lane0 && (wa == `UPC_ADDR_STATUS);
	wire pw_rst_wr    = pw_wr && wd[`UPC_BIT_RST];
	wire resume_end   = pw_wr && !wd[`UPC_BIT_RESUME] && resume_reg;
	// A controller reset is the register-level reset here, applied one cycle after the write.
	wire ctl_rst = !aresetn || soft_rst_reg; // [R6]
	localparam [7:0] power_reset_val = `UPC_POWER_RESET;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg  <= 1'b0;
			w_hold_reg   <= 1'b0;
			aw_addr_reg  <= 12'h000;
			w_data_reg   <= `UPC_ZERO32;
			w_strb_reg   <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `UPC_RESP_OKAY;
			soft_rst_reg <= 1'b0;
		end else begin
			soft_rst_reg <= pw_rst_wr; // [R6]
			if (wr_go) begin
				aw_hold_reg  <= 1'b0;
				w_hold_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= known_addr(wa) ? `UPC_RESP_OKAY : `UPC_RESP_SLVERR;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_hold_reg <= 1'b1;
					aw_addr_reg <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_hold_reg <= 1'b1;
					w_data_reg <= s_axi_wdata;
					w_strb_reg <= s_axi_wstrb;
				end
				if (s_axi_bvalid && s_axi_bready)
					s_axi_bvalid <= 1'b0;
			end
		end
	end

	always @(posedge aclk) begin
		if (ctl_rst) begin
			iso_sof_hold_reg          <= power_reset_val[`UPC_BIT_ISO];
			core_inhibit_reg          <= power_reset_val[`UPC_BIT_INH]; // [R3]
			bus_reset_flag_reg        <= 1'b0;
			resume_reg                <= 1'b0;
			suspend_state_reg         <= 1'b0;
			suspend_detect_enable_reg <= 1'b0;
			resume_seen_reg           <= 1'b0;
			sof_seen_reg              <= 1'b0;
			irq_stat_reg              <= {`UPC_IRQ_W{1'b0}};
			irq_en_reg                <= `UPC_IRQ_EN_RESET;
			function_address_reg      <= 7'h00;
			ev_prev_reg               <= 4'h0;
		end else begin
			ev_prev_reg <= ev_sync;
			if (pw_wr) begin
				iso_sof_hold_reg          <= wd[`UPC_BIT_ISO];
				suspend_detect_enable_reg <= wd[`UPC_BIT_SUSPEND_DETECT_ENABLE];
				resume_reg                <= wd[`UPC_BIT_RESUME]; // [R10]
				if (!wd[`UPC_BIT_INH])
					core_inhibit_reg <= 1'b0; // [R4]
			end
			// The bus-reset flag is status only; it stays until the next controller reset.
			// A bus reset wins over an address write in the same cycle, so the host always finds address zero.
			if (rst_ev) begin
				bus_reset_flag_reg   <= 1'b1; // [R7]
				function_address_reg <= 7'h00; // [R8]
			end else if (fa_wr)
				function_address_reg <= wd[6:0];
			if (sus_ev && suspend_detect_enable_reg)
				suspend_state_reg <= 1'b1; // [R9]
			else if (rst_ev || resume_end || (common_irq_read && resume_seen_reg))
				suspend_state_reg <= 1'b0; // [R9]
			if (res_ev && suspend_state_reg)
				resume_seen_reg <= 1'b1;
			else if (common_irq_read)
				resume_seen_reg <= 1'b0;
			// An armed packet waits for a frame start while iso hold is on.
			if (!in_packet_armed || (in_token && sof_seen_reg))
				sof_seen_reg <= 1'b0;
			else if (sof_ev)
				sof_seen_reg <= 1'b1; // [R1]
			// Sets win over clears so no event is lost in the clearing cycle.
			// A bus reset drops the flags it re-enables; events of the same edge still set theirs.
			irq_stat_reg <= (irq_stat_reg & ~(clr_wr ? wd[`UPC_IRQ_W-1:0] : {`UPC_IRQ_W{1'b0}})
				& ~(rst_ev ? `UPC_IRQ_EN_BUSRST : {`UPC_IRQ_W{1'b0}}))
				| {sof_ev, res_ev, sus_ev && suspend_detect_enable_reg, rst_ev}; // [R8]
			if (rst_ev)
				irq_en_reg <= `UPC_IRQ_EN_BUSRST; // [R8]
			else if (en_wr)
				irq_en_reg <= wd[`UPC_IRQ_W-1:0];
		end
	end

	wire [7:0] power_rd = {iso_sof_hold_reg, 2'b00, core_inhibit_reg, bus_reset_flag_reg,
		resume_reg, suspend_state_reg, suspend_detect_enable_reg}; // [R11]

	// Read channel: one read at a time, answered the cycle after the address is taken.
	assign s_axi_arready = !s_axi_rvalid;
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= `UPC_ZERO32;
			s_axi_rresp  <= `UPC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `UPC_RESP_OKAY;
			if (s_axi_araddr == `UPC_ADDR_POWER)
				s_axi_rdata <= {24'h00_0000, power_rd};
			else if (s_axi_araddr == `UPC_ADDR_IRQ_STAT)
				s_axi_rdata <= {28'h000_0000, irq_stat_reg};
			else if (s_axi_araddr == `UPC_ADDR_IRQ_EN)
				s_axi_rdata <= {28'h000_0000, irq_en_reg};
			else if (s_axi_araddr == `UPC_ADDR_STATUS)
				s_axi_rdata <= {25'h000_0000, function_address_reg};
			else begin
				s_axi_rdata <= `UPC_ZERO32;
				s_axi_rresp <= known_addr(s_axi_araddr) ? `UPC_RESP_OKAY : `UPC_RESP_SLVERR;
			end
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	always @(posedge aclk) begin
		if (ctl_rst) begin
			send_armed      <= 1'b0;
			send_zero_len   <= 1'b0;
			core_enable     <= 1'b0;
			resume_drive    <= 1'b0;
			bus_reset_clear <= 1'b0;
			irq             <= 1'b0;
		end else begin
			send_armed    <= in_token && in_packet_armed && (!iso_sof_hold_reg || sof_seen_reg); // [R1]
			send_zero_len <= in_token && in_packet_armed && iso_sof_hold_reg && !sof_seen_reg; // [R2]
			core_enable   <= !core_inhibit_reg; // [R3]
			resume_drive  <= resume_reg && suspend_state_reg; // [R10]
			bus_reset_clear <= rst_ev; // [R8]
			irq           <= |(irq_stat_reg & irq_en_reg);
		end
	end
endmodule

// ### upc_asserts.sv
`timescale 1ns/100ps
module upc_asserts (
	input wire        aclk,
	input wire        aresetn,
	input wire [11:0] s_axi_awaddr,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        in_token,
	input wire        send_armed,
	input wire        send_zero_len,
	input wire        core_enable,
	input wire        bus_reset_det,
	input wire        bus_reset_clear,
	input wire [6:0]  function_address_reg
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire pw = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == 12'h004;
	property p_tx_arm; send_armed |-> $past(in_token); endproperty
	a_tx_arm: assert property (p_tx_arm) else $error("send without token");
	property p_tx_zero; send_zero_len |-> $past(in_token) && !send_armed; endproperty
	a_tx_zero: assert property (p_tx_zero) else $error("bad zero packet");
	property p_inh_por; !$past(aresetn) |-> !core_enable; endproperty
	a_inh_por: assert property (p_inh_por) else $error("enabled at reset");
	property p_inh_w1; pw && !s_axi_wdata[3] && core_enable |=> core_enable [*3]; endproperty
	a_inh_w1: assert property (p_inh_w1) else $error("inhibit set by write");
	property p_soft; pw && s_axi_wdata[3] |-> ##[1:5] !core_enable; endproperty
	a_soft: assert property (p_soft) else $error("no soft reset");
	property p_det; $rose(bus_reset_det) |-> ##[1:6] bus_reset_clear; endproperty
	a_det: assert property (p_det) else $error("bus reset missed");
	property p_clr; bus_reset_clear |=> !bus_reset_clear; endproperty
	a_clr: assert property (p_clr) else $error("clear too long");
	property p_fa; bus_reset_clear |=> function_address_reg == 7'h00; endproperty
	a_fa: assert property (p_fa) else $error("address kept");
endmodule
bind upc_power_ctrl upc_asserts u_upc_asserts (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .in_token, .send_armed, .send_zero_len, .core_enable,
	.bus_reset_det, .bus_reset_clear, .function_address_reg);

// ### upc_host.sv
`timescale 1ns/100ps
module upc_host (
	input  wire       aclk,
	input  wire       go,
	input  wire [2:0] kind,
	output wire [4:0] ev
);
	logic [4:0] ev_reg = 5'h00;
	logic [2:0] hold = 3'h0;
	assign ev = ev_reg;
	// Levels stay four cycles, in_token only one, so the controller's synchroniser cannot miss them.
	always @(posedge aclk) begin
		hold <= go ? 3'h4 : hold - {2'h0, hold != 3'h0};
		if (go)
			ev_reg <= 5'h01 << kind;
		else if (hold < 3'h2 || ev_reg[1])
			ev_reg <= 5'h00;
	end
endmodule

// ### usb_device_power_control_tb.sv
`timescale 1ns/100ps
module usb_device_power_control_tb;
	logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, arv = 0, go = 0, cir = 0;
	logic        arm = 1, bry = 0, rry = 0;
	logic [3:0]  ws = 4'hf;
	logic [11:0] aa = 0;
	logic [31:0] wd = 0, seed = 32'hcf69_d503;
	logic [7:0]  v;
	logic [2:0]  kind = 0;
	wire         awr, wrr, arr, bv, rv, s_arm, s_zero, irq, cen, rdrv;
	wire  [4:0]  ev;
	wire  [6:0]  fa;
	wire  [1:0]  br, rr;
	wire  [31:0] rdat;
	logic [33:0] q_bus[$];
	logic [1:0]  q_tx[$];
	int          failures = 0, checks_done = 0, cyc = 0;
	initial forever #50 aclk = ~aclk;
	upc_host u_upc_host (.aclk, .go, .kind, .ev);
	upc_power_ctrl u_upc_power_ctrl (.aclk, .aresetn, .s_axi_awaddr(aa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(aa), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .bus_reset_det(ev[2]),
		.bus_suspend_det(ev[3]), .bus_resume_det(ev[4]), .sof_token(ev[0]), .in_token(ev[1]),
		.in_packet_armed(arm), .common_irq_read(cir), .send_armed(s_arm), .send_zero_len(s_zero),
		.core_enable(cen), .resume_drive(rdrv), .bus_reset_clear(), .function_address_reg(fa), .irq);
	function automatic [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string n, input [33:0] e, input [33:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic close_out;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// One access at a time; the expected answer is queued for the monitor.
	task automatic bus(input w, input [11:0] a, input [7:0] d, input [33:0] e);
		bit ta, tw;
		q_bus.push_back(e);
		aa <= a;
		wd <= {24'h0, d};
		awv <= w;
		wv <= w;
		arv <= !w;
		bry <= w;
		rry <= !w;
		do begin
			@(posedge aclk);
			ta |= w ? awr : arr;
			tw |= w ? wrr : arr;
			awv <= awv & !ta;
			wv <= wv & !tw;
			arv <= arv & !ta;
		end while (!(ta && tw));
		do @(posedge aclk); while (!(bv || rv));
	endtask
	task automatic host(input [2:0] k);
		go <= 1;
		kind <= k;
		@(posedge aclk);
		go <= 0;
		repeat (8) @(posedge aclk);
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			close_out;
		end
		if (bv || rv)
			chk("bus", q_bus.pop_front(), bv ? {br, 32'h0} : {rr, rdat});
		if (s_arm || s_zero)
			chk("packet", {32'h0, q_tx.pop_front()}, {32'h0, s_arm, s_zero});
	end
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		bus(0, 12'h004, 0, 34'h10);
		chk("enable", 0, cen);
		seed = lfsr(seed);
		v = seed[7:0] & 8'he1;
		bus(1, 12'h004, v, 0);
		bus(0, 12'h004, 0, {26'h0, v & 8'h81});
		bus(1, 12'h004, v | 8'h10, 0);
		bus(0, 12'h004, 0, {26'h0, v & 8'h81});
		chk("enable", 1, cen);
		// A write with byte lane 0 off must leave the register alone.
		ws <= 4'he;
		bus(1, 12'h004, 8'h74, 0);
		ws <= 4'hf;
		bus(0, 12'h004, 0, {26'h0, v & 8'h81});
		$display("register test done");
		bus(1, 12'h004, 0, 0);
		q_tx.push_back(2'b10);
		host(1);
		bus(1, 12'h004, 8'h80, 0);
		q_tx.push_back(2'b01);
		host(1);
		host(0);
		q_tx.push_back(2'b10);
		host(1);
		arm <= 0;
		host(1);
		arm <= 1;
		$display("iso test done");
		bus(1, 12'h004, 0, 0);
		bus(1, 12'h01c, v | 8'h01, 0);
		bus(0, 12'h01c, 0, {26'h0, (v | 8'h01) & 8'h7f});
		host(2);
		bus(0, 12'h004, 0, 34'h08);
		bus(0, 12'h014, 0, 34'h0d);
		bus(0, 12'h01c, 0, 0);
		chk("function_address_reg", 0, fa);
		bus(0, 12'h010, 0, 34'h01);
		chk("irq", 1, irq);
		bus(1, 12'h014, 0, 0);
		repeat (2) @(posedge aclk);
		chk("irq", 0, irq);
		bus(1, 12'h014, 8'h0f, 0);
		bus(1, 12'h018, 8'h01, 0);
		bus(0, 12'h010, 0, 0);
		chk("irq", 0, irq);
		$display("bus reset test done");
		bus(1, 12'h004, 8'h01, 0);
		host(3);
		bus(0, 12'h004, 0, 34'h0b);
		bus(1, 12'h004, 8'h05, 0);
		@(posedge aclk);
		chk("resume", 1, rdrv);
		bus(1, 12'h004, 8'h01, 0);
		bus(0, 12'h004, 0, 34'h09);
		chk("resume", 0, rdrv);
		host(3);
		host(4);
		cir <= 1;
		@(posedge aclk);
		cir <= 0;
		bus(0, 12'h004, 0, 34'h09);
		$display("suspend test done");
		bus(1, 12'h004, 8'h08, 0);
		repeat (3) @(posedge aclk);
		bus(0, 12'h004, 0, 34'h10);
		chk("enable", 0, cen);
		bus(0, 12'h014, 0, 0);
		bus(0, 12'h0f0, 0, {2'b10, 32'h0});
		$display("soft reset test done");
		close_out;
	end
endmodule
